// *** hw/adr_refresh_ctrl.sv ***
// Strobe driving controller for an asynchronous DRAM with refresh scheduling.
//
// How it works
// - A refresh falls due once every 15.6 us in distributed scheduling.
// - Burst scheduling runs refreshes back to back until all rows are done.
// - No access is started while a refresh or burst is in progress.
// - A burst holds one refresh per row, each lasting a full row cycle.
// - A due refresh waits for the current access, then stalls new requests.
// - Reads and writes run freely whenever no refresh is pending.
// - Row-only refresh places the row address, then lowers the row strobe.
// - Row-only refresh counts rows itself, covering every row each period.
// - Column-first refresh lowers the column strobe before the row strobe.
// - The write strobe is high when the row strobe falls in column-first.
// - Column strobe stays low before and after the row strobe falls.
// - Consecutive column-first refreshes in a burst keep column low and toggle row only.
// - Row-only addresses use bits 0..10 or 0..11 by variant; with ROWS at 1024 the row counter only reaches bits 0..9.
// - Hidden refresh keeps column low, raises row for precharge, then lowers.
// - Read plus hidden refresh takes two row cycles; column-first is preferred.
`timescale 1ns/1ns
`include "adr_cfg.svh"

module adr_refresh_ctrl #(
    parameter int ROWS     = `ADR_ROWS,
    parameter int INTERVAL = `ADR_INTERVAL_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire adr_pkg::adr_req_s    req,
    input  wire logic                 req_valid,
    output logic                      req_ready,
    output logic [`ADR_DQ_W-1:0]      rd_data,
    output logic                      rd_valid,
    input  wire adr_pkg::adr_rf_mode_e rf_mode,
    input  wire logic                 burst_mode,
    output logic                      rf_busy,
    output adr_pkg::adr_pins_s        pins,
    input  wire logic [`ADR_DQ_W-1:0] dq_i
);

    // ************************************************************************
    // State
    // ************************************************************************
    typedef struct packed {
        adr_pkg::adr_state_e      st;
        logic [`ADR_CNT_W-1:0]    cnt;
        logic [`ADR_DEBT_W-1:0]   debt;
        logic [`ADR_ADDR_W-1:0]   rrow;
        logic                     burst;
        logic                     rf_done;
        adr_pkg::adr_req_s        cur;
        adr_pkg::adr_pins_s       pins;
        logic [`ADR_DQ_W-1:0]     rdata;
        logic                     rvalid;
        logic [`ADR_DQ_W-1:0]     s1;
        logic [`ADR_DQ_W-1:0]     s2;
        logic [`ADR_DQ_W-1:0]     s3;
        logic [`ADR_DQ_W-1:0]     dq_st;
    } adr_ctrl_s;

    adr_ctrl_s q_r;
    adr_ctrl_s q_nxt;
    logic      tick;
    logic      start_rf;
    logic      in_rf;

    localparam logic [`ADR_CNT_W-1:0] RC_M1  = `ADR_CNT_W'(`ADR_RC_CYC - 1);
    localparam logic [`ADR_CNT_W-1:0] PRE_M1 = `ADR_CNT_W'(`ADR_PRE_CYC - 1);
    localparam logic [`ADR_CNT_W-1:0] COL_M1 = `ADR_CNT_W'(`ADR_COL_CYC - 1);

    // ************************************************************************
    // Interval timer
    // ************************************************************************
    adr_tick #(
        .INTERVAL (INTERVAL)
    ) u_tick (
        .clk     (clk),
        .reset_n (reset_n),
        .tick    (tick)
    );

    // A burst starts only once a full period of debt has built up.
    assign start_rf = burst_mode ? (q_r.debt >= `ADR_DEBT_W'(ROWS)) : (q_r.debt != '0);
    assign in_rf    = (q_r.st == adr_pkg::ST_RO_ADDR) || (q_r.st == adr_pkg::ST_RO_LOW) ||
                      (q_r.st == adr_pkg::ST_CBR_SET) || (q_r.st == adr_pkg::ST_CBR_LOW) ||
                      (q_r.st == adr_pkg::ST_CBR_GAP) || (q_r.st == adr_pkg::ST_RF_PRE);

    // ************************************************************************
    // Next state
    // ************************************************************************
    always_comb begin
        q_nxt         = q_r;
        q_nxt.rvalid  = 1'b0;
        q_nxt.rf_done = 1'b0;
        // Data pins pass three flops; a change counts once stages two and three agree.
        q_nxt.s1      = dq_i;
        q_nxt.s2      = q_r.s1;
        q_nxt.s3      = q_r.s2;
        if (q_r.s2 == q_r.s3) begin
            q_nxt.dq_st = q_r.s3;
        end
        // Debt rises on each tick until it saturates at all ones and falls on each finished refresh; when both coincide it holds.
        if (tick && !q_r.rf_done && (q_r.debt != '1)) begin
            q_nxt.debt = q_r.debt + `ADR_DEBT_W'(1);
        end else if (!tick && q_r.rf_done) begin
            q_nxt.debt = q_r.debt - `ADR_DEBT_W'(1);
        end
        case (q_r.st)
            adr_pkg::ST_IDLE: begin
                q_nxt.pins = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, addr: q_r.pins.addr,
                               dq_o: q_r.pins.dq_o, dq_oe_n: 1'b1};
                // Refresh wins over a waiting request; the request is simply held off.
                if (start_rf) begin
                    q_nxt.burst = burst_mode;
                    if (rf_mode == adr_pkg::RF_ROW_ONLY) begin
                        q_nxt.st        = adr_pkg::ST_RO_ADDR;
                        q_nxt.pins.addr = q_r.rrow;
                    end else begin
                        q_nxt.st         = adr_pkg::ST_CBR_SET;
                        q_nxt.pins.cas_n = 1'b0;
                    end
                end else if (req_valid) begin
                    q_nxt.cur        = req;
                    q_nxt.st         = adr_pkg::ST_ACT;
                    q_nxt.pins.addr  = req.row;
                    q_nxt.pins.ras_n = 1'b0;
                end
            end
            adr_pkg::ST_ACT: begin
                q_nxt.st           = adr_pkg::ST_COL;
                q_nxt.cnt          = COL_M1;
                q_nxt.pins.addr    = q_r.cur.col;
                q_nxt.pins.cas_n   = 1'b0;
                q_nxt.pins.we_n    = !q_r.cur.write;
                q_nxt.pins.dq_o    = q_r.cur.wdata;
                q_nxt.pins.dq_oe_n = !q_r.cur.write;
            end
            adr_pkg::ST_COL: begin
                if (q_r.cnt != '0) begin
                    q_nxt.cnt = q_r.cnt - `ADR_CNT_W'(1);
                end else begin
                    if (!q_r.cur.write) begin
                        q_nxt.rdata  = q_r.dq_st;
                        q_nxt.rvalid = 1'b1;
                    end
                    q_nxt.pins.dq_oe_n = 1'b1;
                    q_nxt.pins.we_n    = 1'b1;
                    q_nxt.pins.ras_n   = 1'b1;
                    q_nxt.cnt          = PRE_M1;
                    // Hidden refresh: column stays low so the memory keeps driving data.
                    if ((rf_mode == adr_pkg::RF_HIDDEN) && (q_r.debt != '0)) begin
                        q_nxt.st    = adr_pkg::ST_CBR_GAP;
                        q_nxt.burst = 1'b0;
                    end else begin
                        q_nxt.st         = adr_pkg::ST_PRE;
                        q_nxt.pins.cas_n = 1'b1;
                    end
                end
            end
            adr_pkg::ST_PRE: begin
                if (q_r.cnt != '0) begin
                    q_nxt.cnt = q_r.cnt - `ADR_CNT_W'(1);
                end else begin
                    q_nxt.st = adr_pkg::ST_IDLE;
                end
            end
            adr_pkg::ST_RO_ADDR: begin
                q_nxt.st         = adr_pkg::ST_RO_LOW;
                q_nxt.pins.ras_n = 1'b0;
                q_nxt.cnt        = RC_M1;
            end
            adr_pkg::ST_RO_LOW: begin
                if (q_r.cnt != '0) begin
                    q_nxt.cnt = q_r.cnt - `ADR_CNT_W'(1);
                end else begin
                    q_nxt.rf_done    = 1'b1;
                    q_nxt.rrow       = (q_r.rrow == `ADR_ADDR_W'(ROWS - 1)) ? '0 :
                                       q_r.rrow + `ADR_ADDR_W'(1);
                    q_nxt.pins.ras_n = 1'b1;
                    q_nxt.st         = adr_pkg::ST_RF_PRE;
                    q_nxt.cnt        = PRE_M1;
                end
            end
            adr_pkg::ST_CBR_SET: begin
                q_nxt.st         = adr_pkg::ST_CBR_LOW;
                q_nxt.pins.ras_n = 1'b0;
                q_nxt.cnt        = RC_M1;
            end
            adr_pkg::ST_CBR_LOW: begin
                if (q_r.cnt != '0) begin
                    q_nxt.cnt = q_r.cnt - `ADR_CNT_W'(1);
                end else begin
                    q_nxt.rf_done    = 1'b1;
                    q_nxt.pins.ras_n = 1'b1;
                    q_nxt.cnt        = PRE_M1;
                    // Back to back refreshes keep column low and toggle only the row strobe.
                    if (q_r.burst && (q_r.debt > `ADR_DEBT_W'(1))) begin
                        q_nxt.st = adr_pkg::ST_CBR_GAP;
                    end else begin
                        q_nxt.st         = adr_pkg::ST_RF_PRE;
                        q_nxt.pins.cas_n = 1'b1;
                    end
                end
            end
            adr_pkg::ST_CBR_GAP: begin
                if (q_r.cnt != '0) begin
                    q_nxt.cnt = q_r.cnt - `ADR_CNT_W'(1);
                end else begin
                    q_nxt.st         = adr_pkg::ST_CBR_LOW;
                    q_nxt.pins.ras_n = 1'b0;
                    q_nxt.cnt        = RC_M1;
                end
            end
            adr_pkg::ST_RF_PRE: begin
                // The refresh that just ended leaves the debt only at this edge, so judge by the next value.
                if (q_r.cnt != '0) begin
                    q_nxt.cnt = q_r.cnt - `ADR_CNT_W'(1);
                end else if (q_r.burst && (q_nxt.debt != '0)) begin
                    if (rf_mode == adr_pkg::RF_ROW_ONLY) begin
                        q_nxt.st        = adr_pkg::ST_RO_ADDR;
                        q_nxt.pins.addr = q_r.rrow;
                    end else begin
                        q_nxt.st         = adr_pkg::ST_CBR_SET;
                        q_nxt.pins.cas_n = 1'b0;
                    end
                end else begin
                    q_nxt.st = adr_pkg::ST_IDLE;
                end
            end
            default: begin
                q_nxt.st = adr_pkg::ST_IDLE;
            end
        endcase
    end

    // ************************************************************************
    // State register
    // ************************************************************************
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q_r              <= '0;
            q_r.pins.ras_n   <= 1'b1;
            q_r.pins.cas_n   <= 1'b1;
            q_r.pins.we_n    <= 1'b1;
            q_r.pins.dq_oe_n <= 1'b1;
        end else begin
            q_r <= q_nxt;
        end
    end

    // Requests are refused in refresh and whenever a refresh is due.
    assign req_ready = (q_r.st == adr_pkg::ST_IDLE) && !start_rf;
    assign rd_data   = q_r.rdata;
    assign rd_valid  = q_r.rvalid;
    assign rf_busy   = in_rf;
    assign pins      = q_r.pins;

    // ************************************************************************
    // Checks
    // ************************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    localparam int PRE_I = `ADR_PRE_CYC;

    sequence s_cbr_fall;
        $fell(pins.ras_n) && !pins.cas_n;
    endsequence

    property p_no_cmd;
        in_rf |-> !req_ready;
    endproperty
    a_no_cmd: assert property (p_no_cmd) else $error("request accepted during refresh");

    property p_take;
        req_valid && req_ready |=> (q_r.st == adr_pkg::ST_ACT) && !pins.ras_n;
    endproperty
    a_take: assert property (p_take) else $error("accepted request did not start");

    property p_cbr_order;
        s_cbr_fall |-> $past(!pins.cas_n);
    endproperty
    a_cbr_order: assert property (p_cbr_order) else $error("column not low before row fall");

    property p_cbr_we;
        s_cbr_fall |-> pins.we_n && pins.dq_oe_n;
    endproperty
    a_cbr_we: assert property (p_cbr_we) else $error("write strobe low at row fall");

    property p_cbr_hold;
        s_cbr_fall |=> !pins.cas_n;
    endproperty
    a_cbr_hold: assert property (p_cbr_hold) else $error("column hold after row fall broken");

    property p_row_only;
        $fell(pins.ras_n) && pins.cas_n && in_rf |-> pins.addr == $past(pins.addr);
    endproperty
    a_row_only: assert property (p_row_only) else $error("row address not set before row fall");

    property p_row_time;
        $fell(pins.ras_n) |-> !pins.ras_n [*2];
    endproperty
    a_row_time: assert property (p_row_time) else $error("row strobe low too short");

    property p_hidden;
        $rose(pins.ras_n) && !pins.cas_n |-> (!pins.cas_n && pins.ras_n) ##PRE_I $fell(pins.ras_n);
    endproperty
    a_hidden: assert property (p_hidden) else $error("hidden precharge timing wrong");

    property p_burst_go;
        (q_r.st == adr_pkg::ST_RF_PRE) && (q_r.cnt == '0) && q_r.burst && (q_nxt.debt != '0)
            |=> (q_r.st == adr_pkg::ST_RO_ADDR) || (q_r.st == adr_pkg::ST_CBR_SET);
    endproperty
    a_burst_go: assert property (p_burst_go) else $error("burst stopped early");

    property p_no_extra;
        q_r.rf_done |-> (q_r.debt != '0);
    endproperty
    a_no_extra: assert property (p_no_extra) else $error("refresh run without debt");

    property p_debt_down;
        q_r.rf_done && !tick |=> q_r.debt == $past(q_r.debt) - `ADR_DEBT_W'(1);
    endproperty
    a_debt_down: assert property (p_debt_down) else $error("refresh not counted");

endmodule // adr_refresh_ctrl

// *** hw/adr_cfg.svh ***
// Timing and geometry constants of the refresh controller.
`ifndef ADR_CFG_SVH
`define ADR_CFG_SVH

// ****************************************************************************
// Clock, pin and counter widths
// ****************************************************************************
`define ADR_CLK_NS          100
`define ADR_ADDR_W          12
`define ADR_DQ_W            16
`define ADR_CNT_W           3
`define ADR_DEBT_W          13

// ****************************************************************************
// Refresh geometry and times, in their own units
// ****************************************************************************
`define ADR_ROWS            1024
`define ADR_REFRESH_NS      15600
`define ADR_ROW_CYCLE_NS    130
`define ADR_PRECHARGE_NS    50
`define ADR_COL_CYC         5

// ****************************************************************************
// Derived cycle counts: least times round up, the longest interval rounds down
// ****************************************************************************
`define ADR_INTERVAL_CYC    (`ADR_REFRESH_NS / `ADR_CLK_NS)
`define ADR_RC_CYC          ((`ADR_ROW_CYCLE_NS + `ADR_CLK_NS - 1) / `ADR_CLK_NS)
`define ADR_PRE_CYC         ((`ADR_PRECHARGE_NS + `ADR_CLK_NS - 1) / `ADR_CLK_NS)

`endif

// *** hw/adr_pkg.sv ***
// Types shared by the refresh controller, the DRAM model and the testbench.
`include "adr_cfg.svh"

package adr_pkg;

    // ************************************************************************
    // Modes and states
    // ************************************************************************
    typedef enum logic [1:0] {RF_ROW_ONLY, RF_COLUMN_FIRST, RF_HIDDEN} adr_rf_mode_e;

    typedef enum logic [3:0] {
        ST_IDLE, ST_ACT, ST_COL, ST_PRE, ST_RO_ADDR, ST_RO_LOW,
        ST_CBR_SET, ST_CBR_LOW, ST_CBR_GAP, ST_RF_PRE
    } adr_state_e;

    // ************************************************************************
    // Pin group and user request
    // ************************************************************************
    typedef struct packed {
        logic                   ras_n;
        logic                   cas_n;
        logic                   we_n;
        logic [`ADR_ADDR_W-1:0] addr;
        logic [`ADR_DQ_W-1:0]   dq_o;
        logic                   dq_oe_n;
    } adr_pins_s;

    typedef struct packed {
        logic                   write;
        logic [`ADR_ADDR_W-1:0] row;
        logic [`ADR_ADDR_W-1:0] col;
        logic [`ADR_DQ_W-1:0]   wdata;
    } adr_req_s;

endpackage

// *** hw/adr_tick.sv ***
// Free running interval timer that pulses once per refresh interval.
`timescale 1ns/1ns
`include "adr_cfg.svh"

module adr_tick #(
    parameter int INTERVAL = `ADR_INTERVAL_CYC
) (
    input  wire logic clk,
    input  wire logic reset_n,
    output logic      tick
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } adr_tick_s;

    adr_tick_s q_r;
    adr_tick_s q_nxt;

    // Count down and pulse on wrap; interval never exceeds the required rate.
    always_comb begin
        q_nxt      = q_r;
        q_nxt.tick = 1'b0;
        if (q_r.cnt == 16'h0000) begin
            q_nxt.cnt  = 16'(INTERVAL - 1);
            q_nxt.tick = 1'b1;
        end else begin
            q_nxt.cnt = q_r.cnt - 16'h0001;
        end
    end

    // State register.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            q_r <= '0;
        end else begin
            q_r <= q_nxt;
        end
    end

    assign tick = q_r.tick;

    localparam int IV = INTERVAL;

    property p_tick_period;
        @(posedge clk) disable iff (!reset_n)
        tick |-> ##IV tick;
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("refresh tick period wrong");

endmodule // adr_tick

// *** testbench/adr_dram_model.sv ***
// Behavioural model of the asynchronous DRAM that the refresh controller drives.
`timescale 1ns/1ns
`include "adr_cfg.svh"

module adr_dram_model #(
    parameter int ROWS = 4
) (
    input  wire adr_pkg::adr_pins_s pins,
    output logic [`ADR_DQ_W-1:0]    dq_i,
    output int                      cbr_cnt,
    output int                      ro_cnt,
    output logic [`ADR_ADDR_W-1:0]  ro_row,
    output int                      viol
);
    // ********
    // Storage and strobe reactions
    // ********
    logic [`ADR_DQ_W-1:0]   mem [logic [23:0]];
    logic [`ADR_ADDR_W-1:0] row_r;
    logic [`ADR_ADDR_W-1:0] ctr_r;
    logic [`ADR_DQ_W-1:0]   out_r;
    logic                   drive_r;

    // The internal row counter powers up at ROWS - 1, the last row, and has no reset.
    initial begin
        ctr_r   = `ADR_ADDR_W'(ROWS - 1);
        out_r   = 16'h5A3C;
        drive_r = 1'b0;
        row_r   = '0;
        ro_row  = '0;
        cbr_cnt = 0;
        ro_cnt  = 0;
        viol    = 0;
    end

    // Released lines show the inverse of the last value, so a stale sample never looks right.
    assign dq_i = drive_r ? out_r : ~out_r;

    // Column low at the row fall means a refresh from the counter; the address is ignored.
    always @(negedge pins.ras_n) begin
        if (pins.cas_n == 1'b0) begin
            if (pins.we_n !== 1'b1) begin
                viol = viol + 1;
            end
            ctr_r   = (int'(ctr_r) == ROWS - 1) ? '0 : ctr_r + 1'b1;
            cbr_cnt = cbr_cnt + 1;
        end else begin
            row_r  = pins.addr;
            ro_row = pins.addr;
            ro_cnt = ro_cnt + 1;
        end
    end

    // Column fall with the row open: a write stores, a read starts driving the data lines.
    always @(negedge pins.cas_n) begin
        if (pins.ras_n == 1'b0) begin
            if (pins.we_n == 1'b0) begin
                mem[{row_r, pins.addr}] = pins.dq_o;
            end else begin
                out_r   = mem.exists({row_r, pins.addr}) ? mem[{row_r, pins.addr}] : ~out_r;
                drive_r = 1'b1;
            end
        end
    end

    // Read data stays out until the column strobe rises, across a hidden refresh too.
    always @(posedge pins.cas_n) begin
        drive_r = 1'b0;
    end

    // Both sides driving the data lines at once is counted as a fault.
    always @(negedge pins.dq_oe_n) begin
        if (drive_r) begin
            viol = viol + 1;
        end
    end
endmodule // adr_dram_model

// *** testbench/adr_refresh_ctrl_tb.sv ***
// Self-checking testbench of the refresh controller with a DRAM model.
`timescale 1ns/1ns
`include "adr_cfg.svh"

module adr_refresh_ctrl_tb;
    localparam int ROWS     = 4;
    localparam int INTERVAL = 20;
    logic                  clk;
    logic                  reset_n;
    adr_pkg::adr_req_s     req;
    logic                  req_valid;
    logic                  req_ready;
    logic [15:0]           rd_data;
    logic                  rd_valid;
    adr_pkg::adr_rf_mode_e rf_mode;
    logic                  burst_mode;
    logic                  rf_busy;
    adr_pkg::adr_pins_s    pins;
    logic [15:0]           dq_i;
    logic [11:0]           ro_row;
    int                    cbr_cnt, ro_cnt, viol;
    int                    fails = 0;
    int                    n_compared = 0;
    int                    seed = 32'hb790;
    logic [15:0]           expq[$];
    logic [15:0]           shadow[logic [23:0]];
    logic [23:0]           keys[$];

    adr_refresh_ctrl #(.ROWS(ROWS), .INTERVAL(INTERVAL)) i_adr_refresh_ctrl (
        .clk(clk), .reset_n(reset_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
        .rd_data(rd_data), .rd_valid(rd_valid), .rf_mode(rf_mode), .burst_mode(burst_mode),
        .rf_busy(rf_busy), .pins(pins), .dq_i(dq_i));
    adr_dram_model #(.ROWS(ROWS)) i_adr_dram_model (
        .pins(pins), .dq_i(dq_i), .cbr_cnt(cbr_cnt), .ro_cnt(ro_cnt), .ro_row(ro_row), .viol(viol));

    // ********
    // Shared tasks
    // ********
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("Error %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("Compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Holds the request until a falling edge sees ready, so the next rising edge takes it.
    task automatic access(input logic wr, input logic [23:0] key, input logic [15:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        #10;
        req       = '{wr, key[23:12], key[11:0], wd};
        req_valid = 1'b1;
        @(negedge clk);
        while (req_ready !== 1'b1 && n < 400) begin
            n = n + 1;
            @(negedge clk);
        end
        @(posedge clk);
        if (n >= 400) begin
            fails = fails + 1;
            $display("Error req_ready expected 1 seen 0");
        end else if (wr) begin
            shadow[key] = wd;
        end else begin
            expq.push_back(shadow[key]);
        end
        #10;
        req_valid = 1'b0;
    endtask

    // Waits, bounded, until the model sees one more refresh of the chosen kind.
    task automatic wait_cnt(input bit cbr);
        int c0;
        int n;
        c0 = cbr ? cbr_cnt : ro_cnt;
        n  = 0;
        while ((cbr ? cbr_cnt : ro_cnt) == c0 && n < 400) begin
            n = n + 1;
            @(negedge clk);
        end
        check("refresh seen", 1, n < 400);
    endtask

    // A free running clock of 100 ns.
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Each read result is compared with the oldest note; no request may be ready mid-refresh.
    always @(negedge clk) begin
        if (rd_valid === 1'b1) begin
            if (expq.size() == 0) begin
                fails = fails + 1;
                $display("Error rd_valid expected 0 seen 1");
            end else begin
                check("rd_data", expq.pop_front(), rd_data);
            end
        end
        if (rf_busy === 1'b1) begin
            check("req_ready in refresh", 0, req_ready);
        end
    end

    // The span is several times what the sequence needs, so only a hang reaches it.
    initial begin
        #1000000;
        fails = fails + 1;
        $display("Error watchdog expected done seen running");
        end_of_test();
    end

    // Main sequence: reset, idle refresh pacing, row-only coverage, bursts, then traffic.
    initial begin
        int          c0;
        logic [31:0] mask;
        logic [23:0] key;
        reset_n    = 1'b0;
        req        = '0;
        req_valid  = 1'b0;
        rf_mode    = adr_pkg::RF_COLUMN_FIRST;
        burst_mode = 1'b0;
        repeat (12) @(posedge clk);
        #10;
        check("idle strobes", 4'hF, {pins.ras_n, pins.cas_n, pins.we_n, pins.dq_oe_n});
        reset_n = 1'b1;
        repeat (3) @(negedge clk);
        c0 = cbr_cnt;
        repeat (10 * INTERVAL) @(negedge clk);
        check("refreshes in 10 intervals", 10, cbr_cnt - c0);
        @(posedge clk);
        #10;
        rf_mode = adr_pkg::RF_ROW_ONLY;
        wait_cnt(1'b0);
        mask = '0;
        repeat (ROWS) begin
            wait_cnt(1'b0);
            mask = mask | (32'd1 << ro_row);
        end
        check("rows covered", (32'd1 << ROWS) - 1, mask);
        @(posedge clk);
        #10;
        rf_mode    = adr_pkg::RF_COLUMN_FIRST;
        burst_mode = 1'b1;
        wait_cnt(1'b1);
        c0 = cbr_cnt - 1;
        repeat (4 * ROWS) @(negedge clk);
        check("burst length", ROWS, cbr_cnt - c0);
        repeat (2 * INTERVAL) @(negedge clk);
        check("quiet after burst", ROWS, cbr_cnt - c0);
        for (int m = 0; m < 6; m++) begin
            @(posedge clk);
            #10;
            rf_mode    = adr_pkg::adr_rf_mode_e'(m % 3);
            burst_mode = (m >= 3);
            repeat (16) begin
                if (keys.size() == 0 || ($random(seed) & 1)) begin
                    key = 24'($random(seed)) & 24'h007007;
                    keys.push_back(key);
                    access(1'b1, key, 16'($random(seed)));
                end else begin
                    key = keys[$unsigned($random(seed)) % keys.size()];
                    access(1'b0, key, 16'h0000);
                end
            end
        end
        repeat (20) @(negedge clk);
        check("reads outstanding", 0, expq.size());
        check("model faults", 0, viol);
        end_of_test();
    end
endmodule // adr_refresh_ctrl_tb
